// >>> rtl/mmts_defines.vh
`ifndef MMTS_DEFINES_VH
`define MMTS_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_MOD_STATUS 10'h000d
`define IDX_XFER_CTRL 10'h000e
`define IDX_SIZE_CODE 10'h000f
`define IDX_IRQ_STATUS 10'h0010
`define IDX_IRQ_MASK 10'h0011

// Module status word fields
`define ST_PRESENT 0
`define ST_CLOCK 1
`define ST_WPROT 2
`define ST_TYPE_LO 4
`define ST_TYPE_HI 7

// Module type codes
`define TYPE_NONE 4'h0
`define TYPE_EE4K 4'h1
`define TYPE_EE8K 4'h2
`define TYPE_EPROM 4'h4

// Transfer control word fields
`define XC_TO_MOD 0
`define XC_TO_CTRL 1
`define XC_CMP 2
`define XC_RESULT 3
`define XC_ERR_PMODE 12
`define XC_ERR_WPROT 13
`define XC_ERR_CAP 14
`define XC_ERR_NOPROG 15

// Capacities in words, header word included
`define CAP_NONE 16'h0000
`define CAP_4K 16'h1000
`define CAP_8K 16'h2000
`define CAP_CTRL 16'h1000

// Program size codes and threshold (zero length gets the none code, other lengths below 3.2K words the 3.2K code, all others 7.2K)
`define LIM_3K2 16'h0ccd
`define SZ_NONE 8'h00
`define SZ_3K2 8'h04
`define SZ_7K2 8'h08

// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_REFUSED 1
`define IRQ_INSERTED 2
`define IRQ_BITS 3

// Power-up settle count before the strap levels are caught
`define BOOT_CYCLES 2'h3

// Operations
`define OP_TO_MOD 2'h0
`define OP_TO_CTRL 2'h1
`define OP_CMP 2'h2

`define HTRANS_NONSEQ_BIT 1
`define PIN_COUNT 5

`endif

// >>> rtl/memory_module_transfer_status.v
// Function
// - Bit 0 set if module found at power-up
// - Bit 1 set when module has clock
// - Bit 2 set for protected EEPROM or EPROM
// - Bits 4-7 carry module type code
// - Control bit 0 copies controller to module
// - Control bit 1 copies module to controller
// - Bit 2 high during compare, then clears
// - Bit 3 flags mismatch or impossible compare
// - Bit 12 flags refusal in programming mode
// - Bit 13 flags write protected destination
// - Bit 14 flags too little destination capacity
// - Bit 15 flags empty module on upload
// - Bits 0-7 give module program size code
// - Bits 8-15 give controller program size code
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mmts_defines.vh"

module memory_module_transfer_status (
    input wire clk_sys,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    output wire irq,
    input wire prog_mode,
    input wire [15:0] ctrl_prog_len,
    output wire ctrl_rd,
    output wire ctrl_wr,
    output wire [15:0] ctrl_addr,
    output wire [15:0] ctrl_wdata,
    input wire [15:0] ctrl_rdata,
    input wire mod_detect,
    input wire mod_has_clock,
    input wire mod_wp,
    input wire mod_eprom,
    input wire mod_8k,
    output wire mem_req,
    output wire mem_we,
    output wire [15:0] mem_addr,
    output wire [15:0] mem_wdata,
    input wire [15:0] mem_rdata,
    input wire mem_ack
);

    localparam [2:0] S_BOOT = 3'h0;
    localparam [2:0] S_PROBE = 3'h1;
    localparam [2:0] S_IDLE = 3'h2;
    localparam [2:0] S_CRD = 3'h3;
    localparam [2:0] S_CDAT = 3'h4;
    localparam [2:0] S_MEM = 3'h5;
    localparam [2:0] S_CWR = 3'h6;
    localparam [2:0] S_NEXT = 3'h7;

    // Module pins, two-stage synchronised
    wire [`PIN_COUNT-1:0] pin_raw;
    reg [`PIN_COUNT-1:0] pin_meta_r;
    reg [`PIN_COUNT-1:0] pin_sync_r;
    assign pin_raw = {mod_8k, mod_eprom, mod_wp, mod_has_clock, mod_detect};

    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_sync
            always @(posedge clk_sys) begin
                if (rst) begin
                    pin_meta_r[gi] <= 1'b0;
                    pin_sync_r[gi] <= 1'b0;
                end else begin
                    pin_meta_r[gi] <= pin_raw[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    wire det_s = pin_sync_r[0];
    wire clk_s = pin_sync_r[1];
    wire wp_s = pin_sync_r[2];
    wire eprom_s = pin_sync_r[3];
    wire big_s = pin_sync_r[4];

    reg [2:0] state_r;
    reg [1:0] boot_cnt_r;
    reg present_r;
    reg [3:0] type_r;
    reg det_prev_r;
    reg [15:0] mod_len_r;
    reg [1:0] op_r;
    reg [15:0] idx_r;
    reg [15:0] len_r;
    reg [15:0] buf_r;
    reg mismatch_r;
    reg result_r;
    reg [3:0] err_r;
    reg [`IRQ_BITS-1:0] irq_st_r;
    reg [`IRQ_BITS-1:0] irq_mask_r;

    // Bus pipeline
    reg aph_valid_r;
    reg aph_write_r;
    reg [9:0] aph_idx_r;
    reg rd_pend_r;
    reg [31:0] hrdata_r;

    // Present and type are caught once, after power-up settles
    wire eprom_fit = present_r && (type_r == `TYPE_EPROM);
    wire wprot = present_r && (eprom_fit || wp_s);
    wire clock_ok = present_r && clk_s;
    wire [15:0] mod_cap = !present_r ? `CAP_NONE :
                          (type_r == `TYPE_EE4K) ? `CAP_4K : `CAP_8K;
    wire busy = (state_r != S_IDLE) && (state_r != S_BOOT) && (state_r != S_PROBE);

    function [7:0] size_code;
        input [15:0] len;
        begin
            if (len == 16'h0000)
                size_code = `SZ_NONE;
            else if (len < `LIM_3K2)
                size_code = `SZ_3K2;
            else
                size_code = `SZ_7K2;
        end
    endfunction

    wire [15:0] mod_status = {8'h00, type_r, 1'b0, wprot, clock_ok, present_r};
    wire trig_mod = busy && (op_r == `OP_TO_MOD);
    wire trig_ctrl = busy && (op_r == `OP_TO_CTRL);
    wire cmp_run = busy && (op_r == `OP_CMP);
    wire [15:0] xfer_ctrl = {err_r, 8'h00, result_r, cmp_run, trig_ctrl, trig_mod};
    wire [15:0] size_word = {size_code(ctrl_prog_len),
                             size_code(present_r ? mod_len_r : 16'h0000)};

    // Bus decode
    wire aph_take = hsel && htrans[`HTRANS_NONSEQ_BIT] && hready;
    wire wr_now = aph_valid_r && aph_write_r;
    wire wr_ctrl = wr_now && (aph_idx_r == `IDX_XFER_CTRL);
    wire wr_mask = wr_now && (aph_idx_r == `IDX_IRQ_MASK);
    wire rd_irq = rd_pend_r && (aph_idx_r == `IDX_IRQ_STATUS);

    assign hreadyout = !rd_pend_r;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign irq = |(irq_st_r & irq_mask_r);

    reg [31:0] rd_mux;
    always @* begin
        case (aph_idx_r)
            `IDX_MOD_STATUS: rd_mux = {16'h0000, mod_status};
            `IDX_XFER_CTRL: rd_mux = {16'h0000, xfer_ctrl};
            `IDX_SIZE_CODE: rd_mux = {16'h0000, size_word};
            `IDX_IRQ_STATUS: rd_mux = {29'h0000_0000, irq_st_r};
            `IDX_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Reads get one wait state so that hrdata comes from a flip-flop
    always @(posedge clk_sys) begin
        if (rst) begin
            aph_valid_r <= 1'b0;
            aph_write_r <= 1'b0;
            aph_idx_r <= 10'h000;
            rd_pend_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            rd_pend_r <= 1'b0;
            if (aph_take) begin
                aph_valid_r <= 1'b1;
                aph_write_r <= hwrite;
                aph_idx_r <= haddr[11:2];
                rd_pend_r <= !hwrite;
            end else if (hready) begin
                aph_valid_r <= 1'b0;
            end
            if (aph_take && haddr[31:12] != 20'h0_0000)
                aph_idx_r <= 10'h3ff;
            if (rd_pend_r)
                hrdata_r <= rd_mux;
        end
    end

    // Request decode; one operation at a time, lowest bit wins
    wire req_tm = wr_ctrl && hwdata[`XC_TO_MOD];
    wire req_tc = wr_ctrl && !hwdata[`XC_TO_MOD] && hwdata[`XC_TO_CTRL];
    wire req_cmp = wr_ctrl && !hwdata[`XC_TO_MOD] && !hwdata[`XC_TO_CTRL] && hwdata[`XC_CMP];
    wire accept = (state_r == S_IDLE) && (req_tm || req_tc || req_cmp);

    reg [3:0] refuse;
    always @* begin
        refuse = 4'h0;
        if (req_tm) begin
            if (prog_mode)
                refuse = 4'h1;
            else if (wprot)
                refuse = 4'h2;
            else if (ctrl_prog_len >= mod_cap)
                refuse = 4'h4;
        end else if (req_tc) begin
            if (prog_mode)
                refuse = 4'h1;
            else if (!present_r || mod_len_r == 16'h0000)
                refuse = 4'h8;
            else if (mod_len_r >= `CAP_CTRL)
                refuse = 4'h4;
        end
    end

    wire last_word = (idx_r == len_r);
    wire finish = (state_r == S_NEXT) && last_word;
    wire cmp_fail = accept && req_cmp && !present_r;
    wire ev_done = finish || cmp_fail;
    wire ev_refused = accept && (refuse != 4'h0);
    wire ev_insert = (state_r != S_BOOT) && det_s && !det_prev_r;

    assign ctrl_rd = (state_r == S_CRD);
    assign ctrl_wr = (state_r == S_CWR);
    assign ctrl_addr = idx_r;
    assign ctrl_wdata = buf_r;
    assign mem_req = (state_r == S_MEM) || (state_r == S_PROBE);
    assign mem_we = (state_r == S_MEM) && (op_r == `OP_TO_MOD);
    assign mem_addr = idx_r;
    assign mem_wdata = buf_r;

    always @(posedge clk_sys) begin
        if (rst) begin
            state_r <= S_BOOT;
            boot_cnt_r <= 2'h0;
            present_r <= 1'b0;
            type_r <= `TYPE_NONE;
            det_prev_r <= 1'b0;
            mod_len_r <= 16'h0000;
            op_r <= `OP_TO_MOD;
            idx_r <= 16'h0000;
            len_r <= 16'h0000;
            buf_r <= 16'h0000;
            mismatch_r <= 1'b0;
            result_r <= 1'b0;
            err_r <= 4'h0;
        end else begin
            det_prev_r <= det_s;
            case (state_r)
                S_BOOT: begin
                    boot_cnt_r <= boot_cnt_r + 2'h1;
                    if (boot_cnt_r == `BOOT_CYCLES) begin
                        present_r <= det_s;
                        if (!det_s)
                            type_r <= `TYPE_NONE;
                        else if (eprom_s)
                            type_r <= `TYPE_EPROM;
                        else if (big_s)
                            type_r <= `TYPE_EE8K;
                        else
                            type_r <= `TYPE_EE4K;
                        idx_r <= 16'h0000;
                        state_r <= det_s ? S_PROBE : S_IDLE;
                    end
                end
                S_PROBE: begin
                    // Header word 0 holds the stored program length
                    if (mem_ack) begin
                        mod_len_r <= mem_rdata;
                        state_r <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (accept) begin
                        err_r <= refuse;
                        idx_r <= 16'h0000;
                        mismatch_r <= 1'b0;
                        if (req_cmp) begin
                            result_r <= !present_r;
                            op_r <= `OP_CMP;
                            len_r <= ctrl_prog_len;
                            if (present_r)
                                state_r <= S_CRD;
                        end else if (refuse == 4'h0) begin
                            op_r <= req_tm ? `OP_TO_MOD : `OP_TO_CTRL;
                            len_r <= req_tm ? ctrl_prog_len : mod_len_r;
                            state_r <= req_tm ? S_CRD : S_MEM;
                        end
                    end
                end
                S_CRD: begin
                    state_r <= S_CDAT;
                end
                S_CDAT: begin
                    buf_r <= ctrl_rdata;
                    state_r <= S_MEM;
                end
                S_MEM: begin
                    if (mem_ack) begin
                        if (op_r == `OP_TO_CTRL) begin
                            buf_r <= mem_rdata;
                            state_r <= S_CWR;
                        end else begin
                            if (op_r == `OP_CMP && mem_rdata != buf_r)
                                mismatch_r <= 1'b1;
                            state_r <= S_NEXT;
                        end
                    end
                end
                S_CWR: begin
                    state_r <= S_NEXT;
                end
                S_NEXT: begin
                    if (last_word) begin
                        // Leaving busy drops the trigger and compare bits
                        if (op_r == `OP_TO_MOD)
                            mod_len_r <= len_r;
                        if (op_r == `OP_CMP)
                            result_r <= mismatch_r;
                        state_r <= S_IDLE;
                    end else begin
                        idx_r <= idx_r + 16'h0001;
                        state_r <= (op_r == `OP_TO_CTRL) ? S_MEM : S_CRD;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Sticky events; a read clears them, a same-cycle event survives
    wire [`IRQ_BITS-1:0] irq_set = {ev_insert, ev_refused, ev_done};
    always @(posedge clk_sys) begin
        if (rst) begin
            irq_st_r <= {`IRQ_BITS{1'b0}};
            irq_mask_r <= {`IRQ_BITS{1'b0}};
        end else begin
            irq_st_r <= (rd_irq ? {`IRQ_BITS{1'b0}} : irq_st_r) | irq_set;
            if (wr_mask)
                irq_mask_r <= hwdata[`IRQ_BITS-1:0];
        end
    end

endmodule

// >>> dv/mmts_sva.sv
`timescale 1ns/1ps
module mmts_sva (
    input logic clk_sys,
    input logic rst,
    input logic hsel,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic hreadyout,
    input logic hresp,
    input logic ctrl_rd,
    input logic ctrl_wr,
    input logic mem_req,
    input logic mem_we,
    input logic [15:0] mem_addr,
    input logic mem_ack
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic take;
    assign take = hsel && htrans[1] && hready;
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_fast: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    chk_wait_single: assert property (!hreadyout |=> hreadyout)
        else $error("wait state too long");
    chk_mem_hold: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("module access dropped early");
    chk_ack_release: assert property (mem_ack |=> !mem_req)
        else $error("request held after ack");
    chk_ctrl_order: assert property (ctrl_rd |=> !ctrl_rd && !ctrl_wr ##1 mem_req)
        else $error("word copy order wrong");
    chk_boot_quiet: assert property ($fell(rst) |-> (!mem_req && !ctrl_wr) [*3])
        else $error("access during boot settle");
    chk_ctrl_excl: assert property (!(ctrl_rd && ctrl_wr))
        else $error("controller read and write together");
endmodule
bind memory_module_transfer_status mmts_sva i_sva (.clk_sys, .rst, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .ctrl_rd, .ctrl_wr, .mem_req, .mem_we, .mem_addr, .mem_ack);

// >>> dv/mem_module_model.sv
`timescale 1ns/1ps
module mem_module_model (
    input logic clk_sys,
    input logic [3:0] dly,
    input logic mem_req,
    input logic mem_we,
    input logic [15:0] mem_addr,
    input logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] mem [0:15];
    logic [3:0] cnt_r = 4'h0;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
    end
    always @(posedge clk_sys) begin
        mem_ack <= 1'b0;
        // Idle data toggles so a stale word never passes as valid
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (cnt_r == dly) begin
                cnt_r <= 4'h0;
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr[3:0]];
                if (mem_we) mem[mem_addr[3:0]] <= mem_wdata;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "mmts_defines.vh"
module tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, prog_mode = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rv;
    logic [15:0] ctrl_prog_len = 16'h0006, ctrl_rdata = 16'h0000;
    logic [4:0] pins = 5'h00;
    logic [3:0] dly = 4'h0;
    wire hreadyout, hresp, irq, ctrl_rd, ctrl_wr, mem_req, mem_we, mem_ack;
    wire [31:0] hrdata;
    wire [15:0] ctrl_addr, ctrl_wdata, mem_addr, mem_wdata, mem_rdata;
    logic [15:0] cram [0:15];
    int num_errors = 0, cmp_count = 0, cyc = 0;
    logic [4:0] cp [0:3] = '{5'h14, 5'h1a, 5'h11, 5'h00};
    logic [15:0] hdr [0:3] = '{16'h0005, 16'h1000, 16'h0000, 16'h0000};
    logic [15:0] trig [0:3] = '{16'h0001, 16'h0002, 16'h0002, 16'h0002};
    logic [15:0] st [0:3] = '{16'h0015, 16'h0047, 16'h0021, 16'h0000};
    logic [7:0] sz [0:3] = '{8'h04, 8'h08, 8'h00, 8'h00};
    logic [15:0] err [0:3] = '{16'h2000, 16'h4000, 16'h8000, 16'h8000};

    memory_module_transfer_status i_dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq(irq), .prog_mode(prog_mode), .ctrl_prog_len(ctrl_prog_len), .ctrl_rd(ctrl_rd),
        .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata),
        .ctrl_rdata(ctrl_rdata), .mod_detect(pins[4]), .mod_has_clock(pins[3]),
        .mod_wp(pins[2]), .mod_eprom(pins[1]), .mod_8k(pins[0]), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    mem_module_model i_mod (.clk_sys(clk_sys), .dly(dly), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (ctrl_wr) cram[ctrl_addr[3:0]] <= ctrl_wdata;
        ctrl_rdata <= ctrl_rd ? cram[ctrl_addr[3:0]] : ~ctrl_rdata;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report;
        end
    end

    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task tick;
        @(posedge clk_sys);
        #1;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0_0000, idx, 2'h0};
        while (hreadyout !== 1'b1) tick;
        tick;
        htrans <= 2'h0;
        hwdata <= wd;
        while (hreadyout !== 1'b1) tick;
        rv = hrdata;
        tick;
    endtask
    task rd(input logic [9:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        chk(rv, exp);
    endtask
    task wait_idle;
        bus(1'b0, `IDX_XFER_CTRL, 32'h0000_0000);
        for (int n = 0; n < 100 && rv[2:0] !== 3'h0; n++)
            bus(1'b0, `IDX_XFER_CTRL, 32'h0000_0000);
    endtask
    task boot(input logic [4:0] p, input logic [15:0] h);
        pins <= p;
        i_mod.mem[0] = h;
        rst <= 1'b1;
        repeat (4) tick;
        rst <= 1'b0;
        repeat (20) tick;
    endtask

    initial begin
        cram[0] = 16'h0006;
        for (int i = 1; i < 16; i++) cram[i] = {12'ha00, 4'(i)};
        for (int i = 0; i < 4; i++) begin
            boot(cp[i], hdr[i]);
            rd(`IDX_MOD_STATUS, st[i]);
            rd(`IDX_SIZE_CODE, {8'h04, sz[i]});
            bus(1'b1, `IDX_XFER_CTRL, trig[i]);
            rd(`IDX_XFER_CTRL, err[i]);
        end
        bus(1'b1, `IDX_XFER_CTRL, 32'h0000_0004);
        rd(`IDX_XFER_CTRL, 32'h0000_0008);
        rd(`IDX_IRQ_STATUS, 32'h0000_0003);
        rd(`IDX_IRQ_STATUS, 32'h0000_0000);
        $display("test boot and refusal done");
        boot(5'h11, 16'h0000);
        dly <= 4'h3;
        prog_mode <= 1'b1;
        bus(1'b1, `IDX_XFER_CTRL, 32'h0000_0001);
        prog_mode <= 1'b0;
        rd(`IDX_XFER_CTRL, 32'h0000_1000);
        ctrl_prog_len <= 16'h2000;
        bus(1'b1, `IDX_XFER_CTRL, 32'h0000_0001);
        ctrl_prog_len <= 16'h0006;
        rd(`IDX_XFER_CTRL, 32'h0000_4000);
        bus(1'b1, `IDX_IRQ_MASK, 32'h0000_0007);
        rd(`IDX_IRQ_MASK, 32'h0000_0007);
        rd(`IDX_IRQ_STATUS, 32'h0000_0002);
        bus(1'b1, `IDX_XFER_CTRL, 32'h0000_0001);
        rd(`IDX_XFER_CTRL, 32'h0000_0001);
        // Refused request would leave a visible error if not ignored
        prog_mode <= 1'b1;
        bus(1'b1, `IDX_XFER_CTRL, 32'h0000_0002);
        prog_mode <= 1'b0;
        wait_idle;
        chk(rv, 32'h0000_0000);
        for (int i = 0; i < 7; i++) chk(i_mod.mem[i], cram[i]);
        chk(irq, 1'b1);
        rd(`IDX_SIZE_CODE, 32'h0000_0404);
        rd(`IDX_IRQ_STATUS, 32'h0000_0001);
        chk(irq, 1'b0);
        $display("test to module done");
        bus(1'b1, `IDX_XFER_CTRL, 32'h0000_0004);
        rd(`IDX_XFER_CTRL, 32'h0000_0004);
        wait_idle;
        chk(rv, 32'h0000_0000);
        i_mod.mem[3] = 16'h5a5a;
        bus(1'b1, `IDX_XFER_CTRL, 32'h0000_0004);
        wait_idle;
        chk(rv, 32'h0000_0008);
        $display("test compare done");
        bus(1'b1, `IDX_IRQ_MASK, 32'h0000_0000);
        for (int i = 1; i < 7; i++) cram[i] = 16'h0000;
        bus(1'b1, `IDX_XFER_CTRL, 32'h0000_0002);
        rd(`IDX_XFER_CTRL, 32'h0000_000a);
        wait_idle;
        chk(rv, 32'h0000_0008);
        for (int i = 0; i < 7; i++) chk(cram[i], i_mod.mem[i]);
        chk(irq, 1'b0);
        rd(`IDX_IRQ_STATUS, 32'h0000_0001);
        bus(1'b1, `IDX_MOD_STATUS, 32'h0000_ffff);
        rd(`IDX_MOD_STATUS, 32'h0000_0021);
        rd(10'h020, 32'h0000_0000);
        $display("test to controller and map done");
        // Pull and refit the module after boot
        pins <= 5'h01;
        repeat (4) tick;
        pins <= 5'h11;
        repeat (4) tick;
        rd(`IDX_IRQ_STATUS, 32'h0000_0004);
        rd(`IDX_MOD_STATUS, 32'h0000_0021);
        $display("test insertion event done");
        final_report;
    end
endmodule
